// *** adcsc_regs.svh ***
`ifndef ADCSC_REGS_SVH
`define ADCSC_REGS_SVH
`define ADCSC_BYTE_BITS 4'h8
`define ADCSC_LAST_TX_BIT 4'h7
`define ADCSC_CONV_BIT_CNT 4'h3
`define ADCSC_ADDR_RW 0
`define ADCSC_CMD_SD 7
`define ADCSC_CMD_REF 3
`define ADCSC_CMD_CONV 2
`define ADCSC_HS_CODE 5'h01
`define ADCSC_STRAP_WAIT 2'h2
`define ADCSC_RESULT_RST 8'h00
`endif

// *** adcsc_pkg.sv ***
package adcsc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } adcsc_state_t;
endpackage

// *** adcsc_sync.sv ***
`timescale 1ns/1ps
module adcsc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule

// *** adcsc_top.sv ***
`timescale 1ns/1ps
`include "adcsc_regs.svh"
module adcsc_top
    import adcsc_pkg::*;
#(
    // Arbitrary fixed address code
    parameter logic [4:0] FIXED_CODE = 5'h0b
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic select_pin_high,
    input wire logic select_pin_low,
    input wire logic conv_done,
    input wire logic [7:0] conv_result,
    output logic conv_start,
    output logic [2:0] pos_input,
    output logic [2:0] neg_input,
    output logic neg_is_common,
    output logic input_config_select,
    output logic converter_power,
    output logic reference_power,
    output logic hs_mode
);
    function automatic logic [2:0] chan_of(input logic [1:0] pair, input logic odd);
        chan_of = {pair, odd};
    endfunction

    logic [3:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [1:0] strap;
    logic next_scl_d;
    logic next_sda_d;
    logic [1:0] next_strap_cnt;
    logic next_strap_done;
    logic [1:0] next_strap;

    adcsc_sync #(.W(4), .RST_VAL(4'hf)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({scl_in, sda_in, select_pin_high, select_pin_low}),
        .q(pins_s)
    );

    assign scl_s = pins_s[3];
    assign sda_s = pins_s[2];

    always_comb begin
        next_scl_d = scl_s;
        next_sda_d = sda_s;
        next_strap_cnt = strap_cnt;
        next_strap_done = strap_done;
        next_strap = strap;
        if (!strap_done) begin
            if (strap_cnt == `ADCSC_STRAP_WAIT) begin
                next_strap = pins_s[1:0];
                next_strap_done = 1'b1;
            end else begin
                next_strap_cnt = strap_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            strap <= 2'h0;
        end else begin
            scl_d <= next_scl_d;
            sda_d <= next_sda_d;
            strap_cnt <= next_strap_cnt;
            strap_done <= next_strap_done;
            strap <= next_strap;
        end
    end

    logic bus_start;
    logic bus_stop;
    logic scl_rise;
    logic scl_fall;

    assign bus_start = scl_s && scl_d && sda_d && !sda_s;
    assign bus_stop = scl_s && scl_d && !sda_d && sda_s;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;

    adcsc_state_t state;
    adcsc_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic [7:0] tx;
    logic [7:0] next_tx;
    logic [7:0] result;
    logic [7:0] next_result;
    logic nack;
    logic next_nack;
    logic rw;
    logic next_rw;
    logic stretch;
    logic next_stretch;
    logic conv_busy;
    logic next_conv_busy;
    logic conv_keep;
    logic next_conv_keep;
    logic ref_pend;
    logic next_ref_pend;
    logic next_sda_oe;
    logic next_scl_oe;
    logic next_conv_start;
    logic [2:0] next_pos_input;
    logic [2:0] next_neg_input;
    logic next_neg_is_common;
    logic next_input_config_select;
    logic next_converter_power;
    logic next_reference_power;
    logic next_hs_mode;
    logic [2:0] ch;
    logic addr_match;

    // Channel bits as they stand once command bit 4 arrives
    assign ch = {sh[1], sh[0], sda_s};
    assign addr_match = (sh[7:3] == FIXED_CODE) && (sh[2:1] == strap);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_tx = tx;
        next_result = result;
        next_nack = nack;
        next_rw = rw;
        next_stretch = stretch;
        next_conv_busy = conv_busy;
        next_conv_keep = conv_keep;
        next_ref_pend = ref_pend;
        next_sda_oe = sda_oe;
        next_scl_oe = scl_oe;
        next_conv_start = 1'b0;
        next_pos_input = pos_input;
        next_neg_input = neg_input;
        next_neg_is_common = neg_is_common;
        next_input_config_select = input_config_select;
        next_reference_power = reference_power;
        next_hs_mode = hs_mode;

        if (conv_done && conv_busy) begin
            next_result = conv_result;
            next_conv_busy = 1'b0;
        end

        if (bus_start || bus_stop) begin
            if (ref_pend) begin
                next_reference_power = 1'b1;
                next_ref_pend = 1'b0;
            end
            next_sda_oe = 1'b0;
            next_scl_oe = 1'b0;
            next_stretch = 1'b0;
            next_cnt = 4'h0;
            if (bus_stop) begin
                next_state = ST_IDLE;
                next_hs_mode = 1'b0;
            end else begin
                next_state = ST_ADDR;
            end
        end else begin
            unique case (state)
                ST_IDLE, ST_IGNORE: begin
                    next_sda_oe = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        next_sh = {sh[6:0], sda_s};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == `ADCSC_BYTE_BITS) begin
                        if (addr_match) begin
                            next_state = ST_ADDR_ACK;
                            next_sda_oe = 1'b1;
                            next_rw = sh[`ADCSC_ADDR_RW];
                            if (sh[`ADCSC_ADDR_RW] && hs_mode) begin
                                next_stretch = 1'b1;
                                next_scl_oe = 1'b1;
                            end
                        end else begin
                            if (sh[7:3] == `ADCSC_HS_CODE) begin
                                next_hs_mode = 1'b1;
                            end
                            next_state = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (stretch) begin
                        if (!conv_busy) begin
                            next_stretch = 1'b0;
                            next_scl_oe = 1'b0;
                        end
                    end else if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (rw) begin
                            next_state = ST_TX;
                            next_tx = result;
                            next_sda_oe = !result[7];
                        end else begin
                            next_state = ST_CMD;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                ST_CMD: begin
                    if (scl_rise) begin
                        next_sh = {sh[6:0], sda_s};
                        next_cnt = cnt + 4'h1;
                        if (cnt == `ADCSC_CONV_BIT_CNT) begin
                            next_conv_start = 1'b1;
                            next_conv_busy = 1'b1;
                            next_input_config_select = sh[2];
                            next_pos_input = chan_of(ch[1:0], ch[2]);
                            next_neg_input = chan_of(ch[1:0], !ch[2]);
                            next_neg_is_common = sh[2];
                        end
                    end else if (scl_fall && cnt == `ADCSC_BYTE_BITS) begin
                        next_state = ST_CMD_ACK;
                        next_sda_oe = 1'b1;
                        // Bits 1 and 0 take no part
                        next_conv_keep = sh[`ADCSC_CMD_CONV];
                        if (!sh[`ADCSC_CMD_REF]) begin
                            next_reference_power = 1'b0;
                            next_ref_pend = 1'b0;
                        end else if (!reference_power) begin
                            next_ref_pend = 1'b1;
                        end
                    end
                end
                ST_CMD_ACK: begin
                    if (scl_fall) begin
                        next_state = ST_CMD;
                        next_sda_oe = 1'b0;
                        next_cnt = 4'h0;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt == `ADCSC_LAST_TX_BIT) begin
                            next_state = ST_TX_ACK;
                            next_sda_oe = 1'b0;
                            next_cnt = 4'h0;
                        end else begin
                            next_tx = {tx[6:0], 1'b0};
                            next_sda_oe = !tx[6];
                            next_cnt = cnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        next_nack = sda_s;
                    end else if (scl_fall) begin
                        if (nack) begin
                            next_state = ST_IGNORE;
                            next_sda_oe = 1'b0;
                        end else begin
                            next_state = ST_TX;
                            next_tx = result;
                            next_sda_oe = !result[7];
                        end
                    end
                end
            endcase
        end
        next_converter_power = next_conv_busy || next_conv_keep;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            tx <= 8'h00;
            result <= `ADCSC_RESULT_RST;
            nack <= 1'b0;
            rw <= 1'b0;
            stretch <= 1'b0;
            conv_busy <= 1'b0;
            conv_keep <= 1'b0;
            ref_pend <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            conv_start <= 1'b0;
            pos_input <= 3'h0;
            neg_input <= 3'h1;
            neg_is_common <= 1'b0;
            input_config_select <= 1'b0;
            converter_power <= 1'b0;
            reference_power <= 1'b0;
            hs_mode <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sh <= next_sh;
            tx <= next_tx;
            result <= next_result;
            nack <= next_nack;
            rw <= next_rw;
            stretch <= next_stretch;
            conv_busy <= next_conv_busy;
            conv_keep <= next_conv_keep;
            ref_pend <= next_ref_pend;
            sda_oe <= next_sda_oe;
            scl_oe <= next_scl_oe;
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            conv_start <= next_conv_start;
            pos_input <= next_pos_input;
            neg_input <= next_neg_input;
            neg_is_common <= next_neg_is_common;
            input_config_select <= next_input_config_select;
            converter_power <= next_converter_power;
            reference_power <= next_reference_power;
            hs_mode <= next_hs_mode;
        end
    end
endmodule

// *** adcsc_master.sv ***
`timescale 1ns/1ps
module adcsc_master (
    input wire logic clk,
    input wire logic scl_w,
    input wire logic sda_w,
    output logic scl_m,
    output logic sda_m,
    output logic stretched,
    output logic hung
);
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
        stretched = 1'b0;
        hung = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bus condition: (1,0) is START or repeated START, (0,1) is STOP
    task automatic cond(input logic a, input logic b);
        wt(3);
        sda_m <= a;
        wt(3);
        scl_m <= 1'b1;
        wt(4);
        sda_m <= b;
        wt(4);
        if (!b)
            scl_m <= 1'b0;
    endtask
    // Low 5 clk, high 3 clk; waits out a stretched clock
    task automatic bit_io(input logic b, output logic r);
        int k;
        k = 0;
        wt(2);
        sda_m <= b;
        wt(3);
        scl_m <= 1'b1;
        wt(1);
        while (scl_w !== 1'b1 && k < 3000) begin
            k++;
            wt(1);
        end
        if (k > 0)
            stretched = 1'b1;
        // Clock held past the wait limit
        if (k == 3000)
            hung = 1'b1;
        wt(2);
        r = sda_w;
        scl_m <= 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule

// *** adcsc_assertions.sv ***
`timescale 1ns/1ps
module adcsc_assertions (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic conv_done,
    input wire logic conv_start,
    input wire logic [2:0] pos_input,
    input wire logic [2:0] neg_input,
    input wire logic neg_is_common,
    input wire logic input_config_select,
    input wire logic converter_power,
    input wire logic reference_power,
    input wire logic hs_mode
);
    logic scl_d;
    logic sda_d;
    logic [3:0] since_cond;
    logic [3:0] next_since_cond;
    // Cycles since the last START or STOP on the wires
    always_comb begin
        next_since_cond = since_cond;
        if (scl_in && scl_d && sda_in != sda_d)
            next_since_cond = 4'h0;
        else if (since_cond != 4'hf)
            next_since_cond = since_cond + 4'h1;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            since_cond <= 4'hf;
        end else begin
            scl_d <= scl_in;
            sda_d <= sda_in;
            since_cond <= next_since_cond;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    conv_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("conversion start wider than one cycle");
    conv_power_a: assert property (conv_start |=> converter_power)
        else $error("converter not powered after start");
    stretch_hs_a: assert property (scl_oe |-> hs_mode)
        else $error("clock stretched outside high speed");
    stretch_end_a: assert property (scl_oe && conv_done |-> ##[1:3] !scl_oe)
        else $error("stretch kept after conversion end");
    hs_exit_a: assert property (hs_mode && since_cond == 4'h0 && sda_in |-> ##[1:8] !hs_mode)
        else $error("high speed kept after stop");
    ref_on_a: assert property ($rose(reference_power) |-> since_cond < 4'h8)
        else $error("reference on without bus condition");
    se_common_a: assert property (conv_start |=> neg_is_common == input_config_select)
        else $error("common return does not follow input config");
    diff_pair_a: assert property (conv_start ##1 !neg_is_common |-> neg_input == {pos_input[2:1], ~pos_input[0]})
        else $error("differential partner wrong");
    sda_hold_a: assert property (scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe))
        else $error("data changed while clock high");
    cover property (scl_oe && conv_done);
    cover property (conv_start && input_config_select);
    cover property ($rose(reference_power));
endmodule
bind adcsc_top adcsc_assertions u_chk (
    .clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .conv_done(conv_done), .conv_start(conv_start), .pos_input(pos_input), .neg_input(neg_input),
    .neg_is_common(neg_is_common), .input_config_select(input_config_select),
    .converter_power(converter_power), .reference_power(reference_power), .hs_mode(hs_mode)
);

// *** adcsc_tb_top.sv ***
`timescale 1ns/1ps
module adcsc_tb_top;
    // Arbitrary address code
    localparam logic [4:0] CODE = 5'h15;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sel_hi = 1'b1;
    logic sel_lo = 1'b0;
    logic conv_done = 1'b0;
    logic [7:0] conv_result = 8'h00;
    logic scl_out, scl_oe, sda_out, sda_oe, conv_start, neg_is_common, input_config_select;
    logic converter_power, reference_power, hs_mode, scl_m, sda_m, stretched, aa, ca;
    logic [2:0] pos_input;
    logic [2:0] neg_input;
    logic [7:0] rd;
    logic hung;
    wire scl_w = scl_m & (scl_oe ? scl_out : 1'b1);
    wire sda_w = sda_m & (sda_oe ? sda_out : 1'b1);
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int lat = 20;
    int cnt = 0;
    int n_start = 0;
    always #20 clk = ~clk;
    adcsc_top #(.FIXED_CODE(CODE)) dut (
        .clk(clk), .arst_n(arst_n), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_high(sel_hi),
        .select_pin_low(sel_lo), .conv_done(conv_done), .conv_result(conv_result),
        .conv_start(conv_start), .pos_input(pos_input), .neg_input(neg_input),
        .neg_is_common(neg_is_common), .input_config_select(input_config_select),
        .converter_power(converter_power), .reference_power(reference_power), .hs_mode(hs_mode)
    );
    adcsc_master m (
        .clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m),
        .stretched(stretched), .hung(hung)
    );
    // Converter: done pulse lat cycles after start
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (conv_start) begin
            cnt <= lat;
            n_start <= n_start + 1;
        end else if (cnt > 0)
            cnt <= cnt - 1;
        conv_done <= (cnt == 1);
        if (cyc == 40000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] c, input logic do_stop);
        m.cond(1'b1, 1'b0);
        m.wr_byte({CODE, 2'b10, 1'b0}, aa);
        m.wr_byte(c, ca);
        if (do_stop)
            m.cond(1'b0, 1'b1);
    endtask
    task automatic t_channels();
        logic [3:0] k;
        int s;
        for (int i = 0; i < 16; i++) begin
            k = i[3:0];
            s = n_start;
            wr({k, 2'b01, ~k[1:0]}, 1'b1);
            chk({aa, ca}, 2'b11);
            chk(16'(n_start - s), 16'h0001);
            chk(input_config_select, k[3]);
            chk(pos_input, {k[1:0], k[2]});
            chk(neg_is_common, k[3]);
            if (!k[3])
                chk(neg_input, {k[1:0], ~k[2]});
        end
    endtask
    task automatic t_mismatch();
        int s;
        s = n_start;
        for (int i = 0; i < 2; i++) begin
            m.cond(1'b1, 1'b0);
            m.wr_byte(i ? {CODE ^ 5'h10, 3'b100} : {CODE, sel_hi, sel_lo, 1'b0}, aa);
            m.wr_byte(8'h84, ca);
            chk({aa, ca}, 2'b00);
        end
        m.cond(1'b0, 1'b1);
        chk(16'(n_start - s), 16'h0000);
    endtask
    task automatic t_read();
        conv_result <= 8'ha6;
        wr(8'hb4, 1'b0);
        m.cond(1'b1, 1'b0);
        m.wr_byte({CODE, 2'b10, 1'b1}, aa);
        m.rd_byte(1'b0, rd);
        chk(rd, 8'ha6);
        m.rd_byte(1'b1, rd);
        chk({aa, rd}, 9'h1a6);
        m.wt(6);
        chk({sda_oe, stretched}, 2'b00);
        m.cond(1'b0, 1'b1);
    endtask
    task automatic t_power();
        logic [1:0] pd [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
        logic refm = 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr({4'h0, pd[i], 2'b00}, 1'b0);
            chk(reference_power, refm & pd[i][1]);
            m.cond(1'b0, 1'b1);
            refm = pd[i][1];
            m.wt(lat + 4);
            chk({reference_power, converter_power}, {refm, pd[i][0]});
        end
    endtask
    task automatic t_hs();
        lat = 200;
        conv_result <= 8'h3c;
        m.cond(1'b1, 1'b0);
        m.wr_byte(8'h09, aa);
        chk({aa, hs_mode}, 2'b01);
        wr(8'h84, 1'b0);
        m.cond(1'b1, 1'b0);
        m.wr_byte({CODE, 2'b10, 1'b1}, aa);
        m.rd_byte(1'b1, rd);
        chk({aa, stretched, rd}, 10'h33c);
        m.cond(1'b1, 1'b0);
        chk(hs_mode, 1'b1);
        m.cond(1'b0, 1'b1);
        m.wt(6);
        chk(hs_mode, 1'b0);
        lat = 20;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        sel_hi <= 1'b0;
        sel_lo <= 1'b1;
        chk({reference_power, hs_mode}, 2'b00);
        t_channels();
        t_mismatch();
        t_read();
        t_power();
        t_hs();
        chk(hung, 1'b0);
        close_out();
    end
endmodule
